// *** eba_chk.sv ***
// Purpose: port assertions for the access unit
// Assumes: one clock, busy output watched too
// Notes:   WR_CYCLES as in the device
`timescale 1ns/100ps
`default_nettype none
module eba_chk
    import eba_pkg::*;
#(
    parameter int WR_CYCLES = 20
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        writeBusy,
    input wire eba_ioaddr_t ioAddr,
    input wire logic        ioDataSpace,
    input wire logic        ioRd,
    input wire logic        ioWr,
    input wire logic        ioBitOp,
    input wire logic        ioBitVal,
    input wire logic [2:0]  ioBitNum,
    input wire eba_byte_t   ioWrData,
    input wire eba_byte_t   ioRdData,
    input wire logic        cpuStall,
    input wire logic        globalIntEn,
    input wire logic        sleepPowerDown,
    input wire logic        readyIrq,
    input wire logic        clkRunning
);
    // ******************************
    // control decode and helpers
    // ******************************
    logic        isCtrl;
    logic        isHi;
    logic        rdStb;
    logic        wrStb;
    logic        mweSet;
    logic [3:0]  mweHist_q;
    logic [15:0] busyCnt_q;

    function automatic logic bitHit(input logic [2:0] n);
        return ioBitOp ? (ioBitVal && ioBitNum == n) : ioWrData[n];
    endfunction

    // strobes seen on the port
    always_comb begin
        isCtrl = ioDataSpace ? (ioAddr == 7'h3F) : (ioAddr == 7'h1F);
        isHi   = ioDataSpace ? (ioAddr == 7'h42) : (ioAddr == 7'h22);
        rdStb  = ioWr && isCtrl && bitHit(3'h0);
        wrStb  = ioWr && isCtrl && bitHit(3'h1);
        mweSet = ioWr && isCtrl && bitHit(3'h2);
    end

    // enable window history
    always_ff @(posedge clk) begin
        if (!rst_n) mweHist_q <= 4'h0;
        else mweHist_q <= {mweHist_q[2:0], mweSet};
    end

    // busy length, unreset: writes outlive reset
    always_ff @(posedge clk) begin
        if (!writeBusy) busyCnt_q <= 16'h0000;
        else busyCnt_q <= busyCnt_q + 16'h0001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rdStall;
        cpuStall [*4] ##1 !cpuStall;
    endsequence
    sequence s_wrStall;
        cpuStall [*2] ##1 !cpuStall;
    endsequence

    a_rd_stall: assert property (rdStb && !writeBusy |=> s_rdStall)
        else $error("read stall length");
    a_wr_stall: assert property ($rose(writeBusy) |-> s_wrStall)
        else $error("write stall length");
    a_busy_time: assert property ($fell(writeBusy) |-> busyCnt_q == 16'(WR_CYCLES))
        else $error("busy time");
    a_wr_guard: assert property (wrStb && mweHist_q == 4'h0 |=> !$rose(writeBusy))
        else $error("unenabled write started");
    a_wr_start: assert property (wrStb && mweHist_q != 4'h0 && !writeBusy |=> $rose(writeBusy))
        else $error("enabled write missed");
    a_busy_read: assert property (rdStb && writeBusy |=> !cpuStall)
        else $error("read during write");
    a_irq_quiet: assert property (writeBusy || !globalIntEn |-> !readyIrq)
        else $error("ready irq while busy");
    a_clk_awake: assert property (!sleepPowerDown || writeBusy |-> clkRunning)
        else $error("clock stopped");
    a_clk_keep: assert property ($fell(writeBusy) && sleepPowerDown |=> clkRunning [*3])
        else $error("no keep-alive");
    a_addr_hi: assert property (ioRd && isHi |=> ioRdData[7:3] == 5'h00)
        else $error("address high bits set");
endmodule // eba_chk
`default_nettype wire

// *** eba_consts.svh ***
// Purpose: offsets, bit positions and timing
// Assumes: 100 MHz core clock
// Notes:   definitions only
`ifndef EBA_CONSTS_SVH
`define EBA_CONSTS_SVH
// ******************************
// i/o register map
// ******************************
`define EBA_IO_LAST        7'h3F
`define EBA_BIT_IO_LAST    7'h1F
`define EBA_DS_OFFSET      7'h20
`define EBA_DS_LAST        7'h5F
`define EBA_OFF_CTRL       6'h1F
`define EBA_OFF_DATA       6'h20
`define EBA_OFF_ADDR_LO    6'h21
`define EBA_OFF_ADDR_HI    6'h22
// ******************************
// control register bits
// ******************************
`define EBA_BIT_RE         0
`define EBA_BIT_WE         1
`define EBA_BIT_MWE        2
`define EBA_BIT_RIE        3
`define EBA_BIT_DONE       4
// ******************************
// timing
// ******************************
`define EBA_CLK_PERIOD_NS  10
`define EBA_WR_OSC_CYCLES  27072
`define EBA_WR_TIME_NS     3400000
`define EBA_WR_CYCLES      (`EBA_WR_TIME_NS / `EBA_CLK_PERIOD_NS)
`define EBA_MWE_CYCLES     3'd4
`define EBA_RD_STALL       3'd4
`define EBA_WR_STALL       3'd2
// ******************************
// host command and status layout
// ******************************
`define EBA_AXI_CMD        4'h0
`define EBA_AXI_STATUS     4'h4
`define EBA_AXI_CTRL       4'h8
`define EBA_CMD_DATA_LSB   0
`define EBA_CMD_ADDR_LSB   8
`define EBA_CMD_DS         15
`define EBA_CMD_WRITE      16
`define EBA_CMD_BITOP      17
`define EBA_CMD_BITVAL     18
`define EBA_CMD_BITNUM_LSB 20
`define EBA_ST_PEND        8
`define EBA_ST_IRQ         9
`define EBA_ST_CLKRUN      10
`define EBA_CTL_GIE        0
`define EBA_CTL_SLEEP      1
`define EBA_RESP_OKAY      2'h0
`define EBA_RESP_SLVERR    2'h2
`endif

// *** eba_device.sv ***
// Purpose: nv byte access unit, address, data and control registers
// Assumes: host keeps ioRd/ioWr low while cpuStall is high
// Notes:   write engine is reset only by power-on reset
`timescale 1ns/100ps
`default_nettype none
`include "eba_consts.svh"
module eba_device
    import eba_pkg::*;
#(
    parameter int ADDR_W    = 11,
    parameter int WR_CYCLES = `EBA_WR_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic powerOnRst_n,
    input  wire logic clkEn,
    output var  logic writeBusy,
    eba_io_if.dev     io
);
    localparam int DEPTH = 1 << ADDR_W;

    // ******************************
    // decode
    // ******************************
    // fold data-space into i/o offset
    function automatic logic [6:0] decodeOff(input logic ds, input eba_ioaddr_t a);
        logic [6:0] r;
        r = 7'h7F;
        if (ds && a >= `EBA_DS_OFFSET && a <= `EBA_DS_LAST) begin
            r = a - `EBA_DS_OFFSET;
        end else if (!ds && a <= `EBA_IO_LAST) begin
            r = a;
        end
        return r;
    endfunction

    logic [6:0]  offEff;
    logic        bitOk;
    eba_byte_t   wMask;
    eba_byte_t   wVal;
    logic        wrAny;
    logic        hitCtrl;
    logic        hitData;
    logic        hitLo;
    logic        hitHi;

    assign offEff = decodeOff(io.ioDataSpace, io.ioAddr);
    // bit ops only below offset 0x20
    assign bitOk  = io.ioBitOp && (offEff <= `EBA_BIT_IO_LAST);
    assign wrAny  = clkEn && ((io.ioWr && !io.ioBitOp) || (io.ioWr && bitOk));
    // bit op masks a single bit
    assign wMask  = io.ioBitOp ? (8'h01 << io.ioBitNum) : 8'hFF;
    assign wVal   = io.ioBitOp ? (io.ioBitVal ? wMask : 8'h00) : io.ioWrData;
    assign hitCtrl = wrAny && offEff == {1'b0, `EBA_OFF_CTRL};
    assign hitData = wrAny && offEff == {1'b0, `EBA_OFF_DATA};
    assign hitLo   = wrAny && offEff == {1'b0, `EBA_OFF_ADDR_LO};
    assign hitHi   = wrAny && offEff == {1'b0, `EBA_OFF_ADDR_HI};

    // ******************************
    // state
    // ******************************
    // linear byte array
    eba_byte_t          mem [DEPTH];
    logic [10:0]        addr_q;
    eba_byte_t          data_q;
    eba_byte_t          rdData_q;
    logic               mwe_q;
    logic [2:0]         mweCnt_q;
    logic               rie_q;
    logic               done_q;
    logic               busy_q;
    logic [31:0]        wCnt_q;
    logic [2:0]         stall_q;
    logic               keep_q;
    logic               weStart;
    logic               reStart;
    logic               wDone;
    logic [ADDR_W-1:0]  memIdx;

    // bit ten dropped on the 1 KB build
    assign memIdx  = addr_q[ADDR_W-1:0];
    assign weStart = hitCtrl && wMask[`EBA_BIT_WE] && wVal[`EBA_BIT_WE] && mwe_q && !busy_q;
    // read ignored while a write runs
    assign reStart = hitCtrl && wMask[`EBA_BIT_RE] && wVal[`EBA_BIT_RE] && !busy_q;
    assign wDone   = clkEn && busy_q && wCnt_q == 32'(WR_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (!busy_q && hitLo) begin
            addr_q[7:0] <= (addr_q[7:0] & ~wMask) | (wVal & wMask);
        end
        if (!busy_q && hitHi) begin
            addr_q[10:8] <= (addr_q[10:8] & ~wMask[2:0]) | (wVal[2:0] & wMask[2:0]);
        end
    end

    // data register
    always_ff @(posedge clk) begin
        if (reStart) begin
            // fetched byte lands in data register
            data_q <= mem[memIdx];
        end else if (hitData) begin
            data_q <= (data_q & ~wMask) | (wVal & wMask);
        end
    end

    // byte committed when the write starts
    always_ff @(posedge clk) begin
        if (weStart) begin
            mem[memIdx] <= data_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mwe_q    <= 1'b0;
            mweCnt_q <= 3'd0;
        end else if (clkEn) begin
            if (hitCtrl && wMask[`EBA_BIT_MWE] && wVal[`EBA_BIT_MWE]) begin
                mwe_q    <= 1'b1;
                mweCnt_q <= `EBA_MWE_CYCLES - 3'd1;
            end else if (mweCnt_q != 3'd0) begin
                mweCnt_q <= mweCnt_q - 3'd1;
            end else begin
                mwe_q <= 1'b0;
            end
        end
    end

    // interrupt enable and done flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rie_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (clkEn) begin
            if (hitCtrl && wMask[`EBA_BIT_RIE]) begin
                rie_q <= wVal[`EBA_BIT_RIE];
            end
            if (wDone) begin
                done_q <= 1'b1;
            end else if (hitCtrl && wMask[`EBA_BIT_DONE] && wVal[`EBA_BIT_DONE]) begin
                done_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!powerOnRst_n) begin
            busy_q <= 1'b0;
            wCnt_q <= 32'd0;
        end else if (clkEn) begin
            if (weStart) begin
                busy_q <= 1'b1;
                wCnt_q <= 32'd0;
            end else if (wDone) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                wCnt_q <= wCnt_q + 32'd1;
            end
        end
    end

    // sleep does not gate the engine
    always_ff @(posedge clk) begin
        if (!powerOnRst_n) begin
            keep_q <= 1'b0;
        end else if (clkEn) begin
            if (!io.sleepPowerDown) begin
                keep_q <= 1'b0;
            end else if (wDone) begin
                keep_q <= 1'b1;
            end
        end
    end

    // core stall counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stall_q <= 3'd0;
        end else if (clkEn) begin
            if (reStart) begin
                stall_q <= `EBA_RD_STALL;
            end else if (weStart) begin
                // two stalled cycles after write start
                stall_q <= `EBA_WR_STALL;
            end else if (stall_q != 3'd0) begin
                stall_q <= stall_q - 3'd1;
            end
        end
    end

    // read data, unmapped offsets zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_q <= 8'h00;
        end else if (clkEn && io.ioRd) begin
            case (offEff)
                {1'b0, `EBA_OFF_CTRL}: begin
                    rdData_q <= {3'b000, done_q, rie_q, mwe_q, busy_q, 1'b0};
                end
                {1'b0, `EBA_OFF_DATA}: begin
                    rdData_q <= data_q;
                end
                {1'b0, `EBA_OFF_ADDR_LO}: begin
                    rdData_q <= addr_q[7:0];
                end
                // bit ten hidden on the 1 KB build
                {1'b0, `EBA_OFF_ADDR_HI}: begin
                    rdData_q <= {5'b00000, (ADDR_W > 10) & addr_q[10], addr_q[9:8]};
                end
                default: begin
                    rdData_q <= 8'h00;
                end
            endcase
        end
    end

    assign io.ioRdData   = rdData_q;
    assign io.cpuStall   = stall_q != 3'd0;
    // level interrupt while strobe is clear
    assign io.readyIrq   = rie_q && io.globalIntEn && !busy_q;
    assign io.clkRunning = !io.sleepPowerDown || busy_q || keep_q;
    assign writeBusy     = busy_q;
endmodule // eba_device
`default_nettype wire

// *** eba_host.sv ***
// Purpose: core-side end, turns AXI4-Lite commands into i/o accesses
// Assumes: one write, one read in flight
// Notes:   one access per command
`timescale 1ns/100ps
`default_nettype none
`include "eba_consts.svh"
module eba_host
    import eba_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    eba_io_if.host           io
);
    // ******************************
    // axi write side
    // ******************************
    logic        awHeld_q;
    logic [3:0]  awAddr_q;
    logic        wHeld_q;
    logic [31:0] wData_q;
    logic        doWrite;
    logic [31:0] cmd_q;
    logic [1:0]  ctl_q;
    eba_hstate_t st_q;
    eba_byte_t   last_q;

    assign awready = !awHeld_q && !bvalid && clkEn;
    assign wready  = !wHeld_q && !bvalid && clkEn;
    assign doWrite = awHeld_q && wHeld_q && !bvalid && clkEn;

    // capture address and data in either order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q  <= 32'h0;
            bvalid   <= 1'b0;
            bresp    <= `EBA_RESP_OKAY;
        end else if (clkEn) begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid   <= 1'b1;
                // command refused while one is pending
                bresp <= (awAddr_q == `EBA_AXI_CMD && st_q == EBA_IDLE)
                         || awAddr_q == `EBA_AXI_CTRL ? `EBA_RESP_OKAY : `EBA_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // control register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_q <= 2'b00;
        end else if (doWrite && awAddr_q == `EBA_AXI_CTRL && wstrb[0]) begin
            ctl_q <= wData_q[1:0];
        end
    end

    // ******************************
    // i/o access sequencer
    // ******************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q   <= EBA_IDLE;
            cmd_q  <= 32'h0;
            last_q <= 8'h00;
        end else if (clkEn) begin
            case (st_q)
                EBA_IDLE: begin
                    if (doWrite && awAddr_q == `EBA_AXI_CMD) begin
                        cmd_q <= wData_q;
                        st_q  <= EBA_ISSUE;
                    end
                end
                EBA_ISSUE: begin
                    // hold off during stall
                    if (!io.cpuStall) begin
                        st_q <= EBA_HOLD;
                    end
                end
                EBA_HOLD: begin
                    last_q <= io.ioRdData;
                    st_q   <= EBA_IDLE;
                end
                default: begin
                    st_q <= EBA_IDLE;
                end
            endcase
        end
    end

    assign io.ioAddr        = cmd_q[`EBA_CMD_ADDR_LSB +: 7];
    assign io.ioDataSpace   = cmd_q[`EBA_CMD_DS];
    assign io.ioWrData      = cmd_q[`EBA_CMD_DATA_LSB +: 8];
    assign io.ioBitOp       = cmd_q[`EBA_CMD_BITOP];
    assign io.ioBitVal      = cmd_q[`EBA_CMD_BITVAL];
    assign io.ioBitNum      = cmd_q[`EBA_CMD_BITNUM_LSB +: 3];
    assign io.ioWr          = st_q == EBA_ISSUE && !io.cpuStall && cmd_q[`EBA_CMD_WRITE];
    assign io.ioRd          = st_q == EBA_ISSUE && !io.cpuStall && !cmd_q[`EBA_CMD_WRITE];
    assign io.globalIntEn   = ctl_q[`EBA_CTL_GIE];
    assign io.sleepPowerDown = ctl_q[`EBA_CTL_SLEEP];

    // ******************************
    // axi read side
    // ******************************
    assign arready = !rvalid && clkEn;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= `EBA_RESP_OKAY;
        end else if (clkEn) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp  <= `EBA_RESP_OKAY;
                case (araddr)
                    `EBA_AXI_CMD: begin
                        rdata <= cmd_q;
                    end
                    `EBA_AXI_STATUS: begin
                        rdata <= {21'h0, io.clkRunning, io.readyIrq, st_q != EBA_IDLE, last_q};
                    end
                    `EBA_AXI_CTRL: begin
                        rdata <= {30'h0, ctl_q};
                    end
                    default: begin
                        rdata <= 32'h0;
                        rresp <= `EBA_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // eba_host
`default_nettype wire

// *** eba_io_if.sv ***
// Purpose: core i/o register port
// Assumes: one clock, all signals same domain
// Notes:   one access per cycle
`timescale 1ns/100ps
`default_nettype none
interface eba_io_if;
    import eba_pkg::*;
    eba_ioaddr_t ioAddr;
    logic        ioDataSpace;
    logic        ioRd;
    logic        ioWr;
    logic        ioBitOp;
    logic        ioBitVal;
    logic [2:0]  ioBitNum;
    eba_byte_t   ioWrData;
    eba_byte_t   ioRdData;
    logic        cpuStall;
    logic        globalIntEn;
    logic        sleepPowerDown;
    logic        readyIrq;
    logic        clkRunning;
    modport dev (input ioAddr, ioDataSpace, ioRd, ioWr, ioBitOp, ioBitVal, ioBitNum,
                 ioWrData, globalIntEn, sleepPowerDown,
                 output ioRdData, cpuStall, readyIrq, clkRunning);
    modport host (output ioAddr, ioDataSpace, ioRd, ioWr, ioBitOp, ioBitVal, ioBitNum,
                  ioWrData, globalIntEn, sleepPowerDown,
                  input ioRdData, cpuStall, readyIrq, clkRunning);
endinterface
`default_nettype wire

// *** eba_pkg.sv ***
// Purpose: shared types
// Assumes: constants come from eba_consts.svh
// Notes:   types only
package eba_pkg;
    typedef logic [7:0] eba_byte_t;
    typedef logic [6:0] eba_ioaddr_t;
    typedef enum logic [1:0] {
        EBA_IDLE  = 2'h0,
        EBA_ISSUE = 2'h1,
        EBA_HOLD  = 2'h3
    } eba_hstate_t;
endpackage

// *** eeprom_byte_access_unit_tb_top.sv ***
// Purpose: bench for host end and access unit
// Assumes: WR_CYCLES 20, 2 KB array
// Notes:   all traffic goes via host AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module eeprom_byte_access_unit_tb_top
    import eba_pkg::*;
;
    localparam int         WRC = 20;
    localparam logic [7:0] CTL = 8'h1F;
    localparam logic [7:0] DAT = 8'h20;
    localparam logic [7:0] ALO = 8'h21;
    localparam logic [7:0] AHI = 8'h22;
    logic        clk          = 1'b0;
    logic        rst_n        = 1'b0;
    logic        powerOnRst_n = 1'b0;
    logic [3:0]  awaddr       = 4'h0;
    logic        awvalid      = 1'b0;
    logic [31:0] wdata        = 32'h0;
    logic        wvalid       = 1'b0;
    logic        bready       = 1'b0;
    logic [3:0]  araddr       = 4'h0;
    logic        arvalid      = 1'b0;
    logic        rready       = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, writeBusy;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [10:0] addrs [4]    = '{11'h000, 11'h7FF, 11'h3FF, 11'h400};
    eba_byte_t   vals  [4]    = '{8'h5A, 8'hC3, 8'h81, 8'h7E};
    int          fails        = 0;
    int          checked      = 0;
    int          cycles       = 0;

    eba_io_if i_eba_io_if ();
    eba_device #(.ADDR_W(11), .WR_CYCLES(WRC)) i_eba_device (.clk(clk), .rst_n(rst_n),
        .powerOnRst_n(powerOnRst_n), .clkEn(1'b1), .writeBusy(writeBusy), .io(i_eba_io_if));
    eba_host i_eba_host (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .io(i_eba_io_if));
    eba_chk #(.WR_CYCLES(WRC)) i_eba_chk (.clk(clk), .rst_n(rst_n), .writeBusy(writeBusy),
        .ioAddr(i_eba_io_if.ioAddr), .ioDataSpace(i_eba_io_if.ioDataSpace),
        .ioRd(i_eba_io_if.ioRd), .ioWr(i_eba_io_if.ioWr), .ioBitOp(i_eba_io_if.ioBitOp),
        .ioBitVal(i_eba_io_if.ioBitVal), .ioBitNum(i_eba_io_if.ioBitNum),
        .ioWrData(i_eba_io_if.ioWrData), .ioRdData(i_eba_io_if.ioRdData),
        .cpuStall(i_eba_io_if.cpuStall), .globalIntEn(i_eba_io_if.globalIntEn),
        .sleepPowerDown(i_eba_io_if.sleepPowerDown), .readyIrq(i_eba_io_if.readyIrq),
        .clkRunning(i_eba_io_if.clkRunning));

    // ******************************
    // clock, watchdog and report
    // ******************************
    always #5 clk = ~clk;

    // a hung handshake ends the run here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ******************************
    // bus tasks, one edge late to avoid double drives
    // ******************************
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // command words; address bit 7 picks data space
    function automatic logic [31:0] wrW(input logic [7:0] a, input logic [7:0] d);
        return {16'h0001, a, d};
    endfunction
    function automatic logic [31:0] rdW(input logic [7:0] a);
        return {16'h0000, a, 8'h00};
    endfunction
    function automatic logic [31:0] bitW(input logic [7:0] a, input logic [2:0] n, input logic v);
        return {9'h000, n, 1'b0, v, 2'b11, a, 8'h00};
    endfunction

    // one port access; fast skips the poll
    task automatic io(input logic [31:0] c, input bit fast, output eba_byte_t q);
        logic [31:0] s;
        logic [1:0]  r;
        axi_wr(4'h0, c, r);
        check(r, 2'h0, "command accepted");
        s = 32'h0;
        for (int i = 0; i < 50 && !fast; i++) begin
            axi_rd(4'h4, s, r);
            if (s[8] === 1'b0) break;
        end
        q = s[7:0];
    endtask

    task automatic setAddr(input logic [10:0] a);
        eba_byte_t q;
        io(wrW(AHI, {5'h00, a[10:8]}), 0, q);
        io(wrW(ALO, a[7:0]), 0, q);
    endtask

    task automatic waitIdle();
        eba_byte_t q;
        for (int i = 0; i < 100; i++) begin
            io(rdW(CTL), 0, q);
            if (q[1] === 1'b0) break;
        end
        check(q[1], 1'b0, "strobe cleared");
    endtask

    task automatic nvWrite(input logic [10:0] a, input eba_byte_t d);
        eba_byte_t q;
        setAddr(a);
        io(wrW(DAT, d), 0, q);
        io(bitW(CTL, 3'h2, 1'b1), 1, q);
        io(bitW(CTL, 3'h1, 1'b1), 0, q);
    endtask

    task automatic nvRead(input logic [10:0] a, output eba_byte_t q);
        setAddr(a);
        io(wrW(CTL, 8'h01), 0, q);
        io(rdW(DAT), 0, q);
    endtask

    // ******************************
    // test sequence
    // ******************************
    initial begin
        eba_byte_t   q;
        logic [31:0] s;
        logic [1:0]  r;
        repeat (10) @(posedge clk);
        rst_n        <= 1'b1;
        powerOnRst_n <= 1'b1;
        io(wrW(AHI, 8'hFF), 0, q);
        io(rdW(AHI), 0, q);
        check(q, 8'h07, "addr high");
        io(wrW(8'hC1, 8'hA5), 0, q);
        io(rdW(ALO), 0, q);
        check(q, 8'hA5, "data space lo");
        io(wrW(DAT, 8'h3C), 0, q);
        io(rdW(8'hC0), 0, q);
        check(q, 8'h3C, "data hold");
        io(bitW(ALO, 3'h0, 1'b0), 0, q);
        io(rdW(ALO), 0, q);
        check(q, 8'hA5, "high bit op");
        axi_rd(4'hC, s, r);
        check({s, r}, 34'h2, "unmapped read");
        $display("test registers done");
        // edge addresses separate bit ten
        foreach (addrs[i]) begin
            nvWrite(addrs[i], vals[i]);
            waitIdle();
        end
        foreach (addrs[i]) begin
            nvRead(addrs[i], q);
            check(q, vals[i], "byte read back");
        end
        $display("test array done");
        io(rdW(CTL), 0, q);
        check(q, 8'h10, "enable timeout");
        io(bitW(CTL, 3'h3, 1'b1), 0, q);
        io(rdW(CTL), 0, q);
        check(q, 8'h18, "bit set");
        io(bitW(CTL, 3'h4, 1'b1), 0, q);
        io(rdW(CTL), 0, q);
        check(q, 8'h08, "done w1c");
        axi_wr(4'h8, 32'h1, r);
        axi_rd(4'h4, s, r);
        check(s[9], 1'b1, "ready irq");
        // stale enable: polled access misses window
        setAddr(11'h3FF);
        io(wrW(DAT, 8'hEE), 0, q);
        io(bitW(CTL, 3'h2, 1'b1), 0, q);
        io(bitW(CTL, 3'h1, 1'b1), 0, q);
        check(writeBusy, 1'b0, "stale strobe");
        nvRead(11'h3FF, q);
        check(q, 8'h81, "guarded byte");
        $display("test control done");
        nvWrite(11'h2AA, 8'h69);
        axi_wr(4'h8, 32'h2, r);
        waitIdle();
        axi_rd(4'h4, s, r);
        check(s[10], 1'b1, "keep-alive");
        axi_wr(4'h8, 32'h0, r);
        nvRead(11'h2AA, q);
        check(q, 8'h69, "write through sleep");
        $display("test sleep done");
        nvWrite(11'h155, 8'h96);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check(writeBusy, 1'b1, "write survives reset");
        io(wrW(CTL, 8'h01), 1, q);
        io(wrW(ALO, 8'h00), 1, q);
        waitIdle();
        io(rdW(ALO), 0, q);
        check(q, 8'h55, "frozen addr");
        nvRead(11'h155, q);
        check(q, 8'h96, "byte after reset");
        $display("test reset done");
        tally_and_finish();
    end
endmodule // eeprom_byte_access_unit_tb_top
`default_nettype wire
